/* File: dgp_preproc.sv */
// module: per-range-gate doppler preprocessing pipeline
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - each of ten pulses gets magnitude |I| plus |Q|.
// - ten magnitudes summed and halved: five times the average.
// - magnitudes delayed, then compared one by one; any excess sets interference.
// - interference held through the gate's transform, suppressing its crossings.
// - saturation when top four offset-binary bits of I or Q are equal.
// - saturation held over all ten samples, then stored, voiding the gate.
// - canceller forms A-2B+C per rail using ones complement plus carry.
// - canceller steps on each read strobe; first two outputs ignored.
// - canceller path widened from 11 to 13 bits.
// - zero doppler filter sums two five-sample magnitudes on read strobes.
// - last eight canceller outputs of ten go into scratch memory.
// - transform sequenced by a fixed 80-instruction program.
// - 32-bit complex words, 14 of them in scratch memory.
// - combiner takes two complex operands, forms sums and differences, two modes.
// - three columns of passes, each overwriting its consumed inputs.
// - four pass types: real, imaginary, real with multiply, imaginary with multiply.
// - multiply passes first combine operand two with itself in imaginary mode.
// - first load latches operand one; second load latches two, shifts one.
// - combiner results written back; capture pulse grabs left half for multiply.
// - 1/sqrt2 formed as shifted sum 1/2+1/8+1/16+1/64+1/256.
// - real then imaginary products stored, then selectors switched to product.
// - finished transform outputs strobed out to the weighting stage.
// - multiplier adds 0, 1, 3 or 4 to offset truncation.
// - program cycle lasts 7.75 us; instructions carry pulse and address fields.
module dgp_preproc
  import dgp_pkg::*;
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // corner-turning memory readout
  input wire logic MEM_STROBE_I,
  input wire dgp_sample_t MEM_SAMPLE_I,
  // register port
  input wire logic [1:0] REG_ADDR_I,
  input wire logic [REG_W-1:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [REG_W-1:0] REG_RDATA_O,
  // weighting and threshold side
  output logic DFT_STROBE_O,
  output var dgp_result_t DFT_OUT_O,
  output logic [WORD_W-1:0] ZVF_MAG_O,
  output logic BUSY_O
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // offset binary to two's complement, widened to the canceller width
  function automatic logic signed [CANC_W-1:0] to_tc(input logic [SAMPLE_W-1:0] s);
    return {{(CANC_W-SAMPLE_W+1){~s[SAMPLE_W-1]}}, s[SAMPLE_W-2:0]};
  endfunction : to_tc

  // |a| + |b|
  function automatic logic [WORD_W-1:0] abs_sum(input logic signed [WORD_W-1:0] a,
                                                input logic signed [WORD_W-1:0] b);
    logic [WORD_W-1:0] ma;
    logic [WORD_W-1:0] mb;
    ma = a[WORD_W-1] ? WORD_W'(-a) : WORD_W'(a);
    mb = b[WORD_W-1] ? WORD_W'(-b) : WORD_W'(b);
    return WORD_W'(ma + mb);
  endfunction : abs_sum

  // a - 2b + c, subtraction by ones complement and a carry of one
  function automatic logic signed [CANC_W-1:0] cancel(input logic signed [CANC_W-1:0] a,
                                                      input logic signed [CANC_W-1:0] b,
                                                      input logic signed [CANC_W-1:0] c);
    logic [CANC_W-1:0] twob;
    twob = {b[CANC_W-2:0], 1'b0};
    return CANC_W'(a + c + (~twob) + 13'h1);
  endfunction : cancel

  // complex combiner: mode real sums/differences, mode imaginary rotates x2
  function automatic dgp_pair_t combine(input dgp_cplx_t x1, input dgp_cplx_t x2,
                                        input logic mode_i);
    dgp_pair_t r;
    if (!mode_i) begin
      r.y1.re = WORD_W'(x1.re + x2.re);
      r.y1.im = WORD_W'(x1.im + x2.im);
      r.y2.re = WORD_W'(x1.re - x2.re);
      r.y2.im = WORD_W'(x1.im - x2.im);
    end else begin
      r.y1.re = WORD_W'(x1.re - x2.im);
      r.y1.im = WORD_W'(x1.im + x2.re);
      r.y2.re = WORD_W'(x1.re + x2.im);
      r.y2.im = WORD_W'(x1.im - x2.re);
    end
    return r;
  endfunction : combine

  // shift-add 1/sqrt2 with truncation correction
  function automatic logic signed [WORD_W-1:0] mul_isqrt2(input logic signed [WORD_W-1:0] x);
    logic signed [WORD_W-1:0] s;
    logic [2:0] c;
    if (!x[WORD_W-1]) begin
      c = (x[2:0] == 3'h0) ? CORR_POS_DIV8 : CORR_POS_OTHER;
    end else begin
      c = x[0] ? CORR_NEG_ODD : CORR_NEG_EVEN;
    end
    s = WORD_W'((x >>> 1) + (x >>> 3) + (x >>> 4) + (x >>> 6) + (x >>> 8));
    return WORD_W'(s + $signed({13'h0, c}));
  endfunction : mul_isqrt2

  // three-bit bit reversal for in-place transform order
  function automatic logic [2:0] bitrev3(input logic [2:0] k);
    return {k[0], k[1], k[2]};
  endfunction : bitrev3

  // one step of one pass
  function automatic dgp_instr_t pass_step(input dgp_pass_t ps, input logic [3:0] step);
    dgp_instr_t ins;
    ins.pulse = P_NOP;
    ins.mode_i = ps.kind[0];
    ins.addr = {1'b0, ps.a};
    unique case ({ps.kind[1], step})
      5'h00: ins.pulse = P_FIRST_OPERAND_LOAD;
      5'h01: begin
        ins.pulse = P_SECOND_OPERAND_LOAD;
        ins.addr = {1'b0, ps.b};
      end
      5'h02: ins.pulse = P_WRITE_Y1;
      5'h03: begin
        ins.pulse = P_WRITE_Y2;
        ins.addr = {1'b0, ps.b};
      end
      5'h10: begin
        ins.pulse = P_FIRST_OPERAND_LOAD;
        ins.addr = {1'b0, ps.b};
      end
      5'h11: begin
        ins.pulse = P_SECOND_OPERAND_LOAD;
        ins.addr = {1'b0, ps.b};
      end
      5'h12: begin
        ins.pulse = P_CAPTURE;
        ins.mode_i = 1'b1;
      end
      5'h13: ins.pulse = P_MUL_RE;
      5'h14: ins.pulse = P_MUL_IM;
      5'h15: ins.pulse = P_FIRST_OPERAND_LOAD;
      5'h16: ins.pulse = P_XFER_SECOND_OPERAND_LOAD;
      5'h17: ins.pulse = P_WRITE_Y1;
      5'h18: begin
        ins.pulse = P_WRITE_Y2;
        ins.addr = {1'b0, ps.b};
      end
      default: ins.pulse = P_NOP;
    endcase
    return ins;
  endfunction : pass_step

  // hard-wired program: twelve passes, eight output strobes, then idle
  function automatic dgp_instr_t decode(input logic [6:0] pc);
    dgp_instr_t ins;
    int start;
    int len;
    int step;
    ins = '{P_NOP, 1'b0, 4'h0};
    start = 0;
    for (int p = 0; p < PASS_COUNT; p++) begin
      len = PASS_TABLE[p].kind[1] ? MULT_STEPS : PLAIN_STEPS;
      step = int'(pc) - start;
      if (step >= 0 && step < len) begin
        ins = pass_step(PASS_TABLE[p], step[3:0]);
      end
      start = start + len;
    end
    if (int'(pc) >= EMIT_START && int'(pc) < EMIT_START + DFT_N) begin
      ins = '{P_EMIT, 1'b0, 4'(int'(pc) - EMIT_START)};
    end
    return ins;
  endfunction : decode

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [3:0] cnt_ff;
  logic [REG_W-1:0] gates_ff;
  logic [MAG_W-1:0] mag_sr_ff [GATE_LEN];
  logic [WORD_W-1:0] mag_sum_ff;
  logic [WORD_W-1:0] ref_ff;
  logic cmp_run_ff;
  logic [3:0] cmp_idx_ff;
  logic int_run_ff;
  logic int_gate_ff;
  logic sat_run_ff;
  logic sat_gate_ff;
  logic signed [CANC_W-1:0] a_i_ff, a_q_ff, b_i_ff, b_q_ff;
  logic signed [ACC_W-1:0] acc_i_ff, acc_q_ff;
  logic [WORD_W-1:0] zmag1_ff;
  logic [WORD_W-1:0] zvf_hold_ff;
  logic busy_ff;
  logic half_ff;
  logic [6:0] pc_ff;
  dgp_cplx_t scratch_ff [SCRATCH_WORDS];
  dgp_cplx_t op1_ff, op1b_ff, op2_ff, cap_ff, prod_ff;

  // ----------------------------------------------------------------
  // sample front end decode
  // ----------------------------------------------------------------
  // group position and register writes
  wire resync = REG_WR_I && (REG_ADDR_I == REG_CTRL) && REG_WDATA_I[CTRL_RESYNC_BIT];
  wire first = MEM_STROBE_I && (cnt_ff == 4'h0);
  wire last = MEM_STROBE_I && (cnt_ff == 4'(GATE_LEN - 1));
  wire signed [CANC_W-1:0] cur_i = to_tc(MEM_SAMPLE_I.i);
  wire signed [CANC_W-1:0] cur_q = to_tc(MEM_SAMPLE_I.q);
  // magnitude of this pulse
  wire [WORD_W-1:0] mag_full = abs_sum({{3{cur_i[CANC_W-1]}}, cur_i},
                                       {{3{cur_q[CANC_W-1]}}, cur_q});
  wire [MAG_W-1:0] mag = mag_full[MAG_W-1:0];
  wire [WORD_W-1:0] sum_now = first ? mag_full : WORD_W'(mag_sum_ff + mag_full);
  // top four bits all ones or all zeros on either rail
  wire [SAT_BITS-1:0] top_i = MEM_SAMPLE_I.i[SAMPLE_W-1 -: SAT_BITS];
  wire [SAT_BITS-1:0] top_q = MEM_SAMPLE_I.q[SAMPLE_W-1 -: SAT_BITS];
  wire sat_hit = MEM_STROBE_I && ((&top_i) || !(|top_i) || (&top_q) || !(|top_q));
  wire sat_acc = (first ? 1'b0 : sat_run_ff) | sat_hit;
  // sequential comparison against five times the average
  wire cmp_hit = cmp_run_ff && ({4'h0, mag_sr_ff[cmp_idx_ff]} > ref_ff);
  wire cmp_done = cmp_run_ff && (cmp_idx_ff == 4'(GATE_LEN - 1));
  wire int_acc = cmp_hit | (first ? 1'b0 : int_run_ff);

  // ----------------------------------------------------------------
  // canceller and zero doppler filter
  // ----------------------------------------------------------------
  wire signed [CANC_W-1:0] canc_i = cancel(a_i_ff, b_i_ff, cur_i);
  wire signed [CANC_W-1:0] canc_q = cancel(a_q_ff, b_q_ff, cur_q);
  wire canc_we = MEM_STROBE_I && (cnt_ff >= 4'(CANC_SKIP));
  wire [2:0] canc_addr = bitrev3(3'(cnt_ff - 4'(CANC_SKIP)));
  wire zvf_start = (cnt_ff == 4'h0) || (cnt_ff == 4'(HALF_LEN));
  wire signed [ACC_W-1:0] zsum_i = zvf_start ? ACC_W'(cur_i) : ACC_W'(acc_i_ff + cur_i);
  wire signed [ACC_W-1:0] zsum_q = zvf_start ? ACC_W'(cur_q) : ACC_W'(acc_q_ff + cur_q);
  wire [WORD_W-1:0] zmag = abs_sum(WORD_W'(zsum_i), WORD_W'(zsum_q));

  // ----------------------------------------------------------------
  // transform datapath decode
  // ----------------------------------------------------------------
  wire dgp_instr_t ins = decode(pc_ff);
  wire exec = busy_ff && !half_ff;
  wire dgp_pulse_t pulse = exec ? ins.pulse : P_NOP;
  wire dgp_cplx_t rd_word = scratch_ff[ins.addr];
  wire dgp_pair_t comb = combine(op1b_ff, op2_ff, ins.mode_i);
  wire pc_end = (pc_ff == 7'(PROG_LEN - 1));
  wire slow = (int'(pc_ff) < SLOW_INSTR);

  // ----------------------------------------------------------------
  // group counter and gate counter
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!NRST_I || resync) begin
      cnt_ff <= 4'h0;
    end else if (MEM_STROBE_I) begin
      cnt_ff <= last ? 4'h0 : 4'(cnt_ff + 4'h1);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      gates_ff <= GATES_RESET;
    end else if (last) begin
      gates_ff <= REG_W'(gates_ff + 16'h1);
    end
  end

  // ----------------------------------------------------------------
  // interference eliminator
  // ----------------------------------------------------------------
  // magnitude delay line, sum and reference
  always_ff @(posedge CLK_I) begin
    if (MEM_STROBE_I) begin
      mag_sr_ff[0] <= mag;
      for (int k = 1; k < GATE_LEN; k++) mag_sr_ff[k] <= mag_sr_ff[k-1];
      mag_sum_ff <= sum_now;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      ref_ff <= 16'h0000;
      cmp_run_ff <= 1'b0;
      cmp_idx_ff <= 4'h0;
      int_run_ff <= 1'b0;
      int_gate_ff <= 1'b0;
    end else begin
      if (last) begin
        ref_ff <= sum_now >> 1;
        cmp_run_ff <= 1'b1;
        cmp_idx_ff <= 4'h0;
      end else if (cmp_run_ff) begin
        cmp_run_ff <= !cmp_done;
        cmp_idx_ff <= 4'(cmp_idx_ff + 4'h1);
      end
      if (MEM_STROBE_I || cmp_run_ff) begin
        int_run_ff <= int_acc;
      end
      if (cmp_done) begin
        int_gate_ff <= int_acc;
      end
    end
  end

  // ----------------------------------------------------------------
  // saturation detector
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      sat_run_ff <= 1'b0;
      sat_gate_ff <= 1'b0;
    end else if (MEM_STROBE_I) begin
      sat_run_ff <= sat_acc;
      if (last) begin
        sat_gate_ff <= sat_acc;
      end
    end
  end

  // ----------------------------------------------------------------
  // canceller and zero doppler filter registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      a_i_ff <= 13'h0000;
      a_q_ff <= 13'h0000;
      b_i_ff <= 13'h0000;
      b_q_ff <= 13'h0000;
      acc_i_ff <= 14'h0000;
      acc_q_ff <= 14'h0000;
      zmag1_ff <= 16'h0000;
      zvf_hold_ff <= 16'h0000;
    end else if (MEM_STROBE_I) begin
      a_i_ff <= b_i_ff;
      a_q_ff <= b_q_ff;
      b_i_ff <= cur_i;
      b_q_ff <= cur_q;
      acc_i_ff <= zsum_i;
      acc_q_ff <= zsum_q;
      if (cnt_ff == 4'(HALF_LEN - 1)) begin
        zmag1_ff <= zmag;
      end
      if (last) begin
        zvf_hold_ff <= WORD_W'(zmag1_ff + zmag);
      end
    end
  end

  // ----------------------------------------------------------------
  // transform controller: 75 two-cycle then 5 one-cycle instructions
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      busy_ff <= 1'b0;
      half_ff <= 1'b0;
      pc_ff <= 7'h00;
    end else if (last) begin
      busy_ff <= 1'b1;
      half_ff <= 1'b0;
      pc_ff <= 7'h00;
    end else if (busy_ff) begin
      if (slow && !half_ff) begin
        half_ff <= 1'b1;
      end else begin
        half_ff <= 1'b0;
        pc_ff <= 7'(pc_ff + 7'h01);
        busy_ff <= !pc_end;
      end
    end
  end

  // ----------------------------------------------------------------
  // scratch memory: canceller loads, combiner write-back
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (canc_we) begin
      scratch_ff[canc_addr] <= '{WORD_W'(canc_i), WORD_W'(canc_q)};
    end else if (pulse == P_WRITE_Y1) begin
      scratch_ff[ins.addr] <= comb.y1;
    end else if (pulse == P_WRITE_Y2) begin
      scratch_ff[ins.addr] <= comb.y2;
    end
  end

  // ----------------------------------------------------------------
  // operand registers, capture and multiplier
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      op1_ff <= '0;
      op1b_ff <= '0;
      op2_ff <= '0;
      cap_ff <= '0;
      prod_ff <= '0;
    end else begin
      unique case (pulse)
        P_FIRST_OPERAND_LOAD: op1_ff <= rd_word;
        P_SECOND_OPERAND_LOAD: begin
          op2_ff <= rd_word;
          op1b_ff <= op1_ff;
        end
        P_XFER_SECOND_OPERAND_LOAD: begin
          op2_ff <= prod_ff;
          op1b_ff <= op1_ff;
        end
        P_CAPTURE: cap_ff <= comb.y1;
        P_MUL_RE: prod_ff.re <= mul_isqrt2(cap_ff.re);
        P_MUL_IM: prod_ff.im <= mul_isqrt2(cap_ff.im);
        default: op1_ff <= op1_ff;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // output strobes to weighting and threshold logic
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      DFT_STROBE_O <= 1'b0;
      DFT_OUT_O <= '0;
      ZVF_MAG_O <= 16'h0000;
      BUSY_O <= 1'b0;
    end else begin
      DFT_STROBE_O <= (pulse == P_EMIT);
      BUSY_O <= busy_ff;
      if (pulse == P_EMIT) begin
        DFT_OUT_O <= '{rd_word, ins.addr[2:0], int_gate_ff, sat_gate_ff};
        if (ins.addr == 4'h0) begin
          ZVF_MAG_O <= zvf_hold_ff;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!NRST_I || !REG_RD_I) begin
      REG_RDATA_O <= 16'h0000;
    end else begin
      unique case (REG_ADDR_I)
        REG_STATUS: REG_RDATA_O <= {9'h000, busy_ff, int_gate_ff, sat_gate_ff, cnt_ff};
        REG_GATES: REG_RDATA_O <= gates_ff;
        default: REG_RDATA_O <= 16'h0000;
      endcase
    end
  end

endmodule : dgp_preproc

`default_nettype wire

/* File: dgp_pkg.sv */
// package: constants and types shared by the doppler gate preprocessor
package dgp_pkg;

  // ----------------------------------------------------------------
  // data widths
  // ----------------------------------------------------------------
  localparam int SAMPLE_W = 11;
  localparam int CANC_W = 13;
  localparam int WORD_W = 16;
  localparam int MAG_W = 12;
  localparam int ACC_W = 14;
  localparam int REG_W = 16;

  // ----------------------------------------------------------------
  // gate and transform geometry
  // ----------------------------------------------------------------
  localparam int GATE_LEN = 10;
  localparam int HALF_LEN = 5;
  localparam int CANC_SKIP = 2;
  localparam int DFT_N = 8;
  localparam int SCRATCH_WORDS = 14;
  localparam int SAT_BITS = 4;
  localparam int PROG_LEN = 80;
  localparam int PASS_COUNT = 12;
  localparam int PLAIN_STEPS = 4;
  localparam int MULT_STEPS = 9;
  localparam int EMIT_START = 58;

  // ----------------------------------------------------------------
  // timing: one program cycle in 7.75 us at a 50 ns clock
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int PROG_TIME_NS = 7750;
  localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int SLOW_INSTR = PROG_CYCLES - PROG_LEN;

  // ----------------------------------------------------------------
  // multiplier truncation corrections
  // ----------------------------------------------------------------
  localparam logic [2:0] CORR_POS_DIV8 = 3'h0;
  localparam logic [2:0] CORR_POS_OTHER = 3'h1;
  localparam logic [2:0] CORR_NEG_EVEN = 3'h3;
  localparam logic [2:0] CORR_NEG_ODD = 3'h4;

  // ----------------------------------------------------------------
  // register map and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_GATES = 2'h2;
  localparam int CTRL_RESYNC_BIT = 0;
  localparam logic [REG_W-1:0] GATES_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SAMPLE_W-1:0] i;
    logic [SAMPLE_W-1:0] q;
  } dgp_sample_t;

  typedef struct packed {
    logic signed [WORD_W-1:0] re;
    logic signed [WORD_W-1:0] im;
  } dgp_cplx_t;

  typedef struct packed {
    dgp_cplx_t y1;
    dgp_cplx_t y2;
  } dgp_pair_t;

  typedef struct packed {
    dgp_cplx_t word;
    logic [2:0] bin;
    logic interference;
    logic saturated;
  } dgp_result_t;

  typedef enum logic [3:0] {
    P_NOP = 4'h0,
    P_FIRST_OPERAND_LOAD = 4'h1,
    P_SECOND_OPERAND_LOAD = 4'h2,
    P_XFER_SECOND_OPERAND_LOAD = 4'h3,
    P_CAPTURE = 4'h4,
    P_MUL_RE = 4'h5,
    P_MUL_IM = 4'h6,
    P_WRITE_Y1 = 4'h7,
    P_WRITE_Y2 = 4'h8,
    P_EMIT = 4'h9
  } dgp_pulse_t;

  typedef struct packed {
    dgp_pulse_t pulse;
    logic mode_i;
    logic [3:0] addr;
  } dgp_instr_t;

  // pass kind: bit1 = multiplier pass, bit0 = imaginary-mode final combine
  typedef struct packed {
    logic [1:0] kind;
    logic [2:0] a;
    logic [2:0] b;
  } dgp_pass_t;

  localparam logic [1:0] PASS_T1 = 2'h0;
  localparam logic [1:0] PASS_T2 = 2'h1;
  localparam logic [1:0] PASS_T3 = 2'h2;
  localparam logic [1:0] PASS_T4 = 2'h3;

  // in-place butterflies over bit-reversed inputs, three columns of four
  localparam dgp_pass_t PASS_TABLE [PASS_COUNT] = '{
    '{PASS_T1, 3'h0, 3'h1}, '{PASS_T1, 3'h2, 3'h3},
    '{PASS_T1, 3'h4, 3'h5}, '{PASS_T1, 3'h6, 3'h7},
    '{PASS_T1, 3'h0, 3'h2}, '{PASS_T2, 3'h1, 3'h3},
    '{PASS_T1, 3'h4, 3'h6}, '{PASS_T2, 3'h5, 3'h7},
    '{PASS_T1, 3'h0, 3'h4}, '{PASS_T3, 3'h1, 3'h5},
    '{PASS_T2, 3'h2, 3'h6}, '{PASS_T4, 3'h3, 3'h7}
  };

endpackage : dgp_pkg

/* File: dgp_preproc_props.sv */
// checker: port assertions for the doppler gate preprocessor
`timescale 1ns/1ps
`default_nettype none
module dgp_preproc_props
  import dgp_pkg::*;
(
  // clock, reset, memory strobe and register port
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic MEM_STROBE_I,
  input wire logic [1:0] REG_ADDR_I,
  input wire logic REG_RD_I,
  input wire logic [REG_W-1:0] REG_RDATA_O,
  // weighting side
  input wire logic DFT_STROBE_O,
  input wire dgp_result_t DFT_OUT_O,
  input wire logic [WORD_W-1:0] ZVF_MAG_O,
  input wire logic BUSY_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  logic [7:0] busy_len_ff;
  // length of the current busy run
  always_ff @(posedge CLK_I) begin
    busy_len_ff <= (NRST_I && BUSY_O) ? busy_len_ff + 8'h1 : 8'h0;
  end
  a_rdata_one_cycle: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == '0)
    else $error("read data outside its cycle");
  a_unmapped_zero: assert property ($past(REG_RD_I) && $past(REG_ADDR_I) == 2'h3
    |-> REG_RDATA_O == '0) else $error("unmapped read not zero");
  a_busy_start: assert property ($rose(BUSY_O) |-> $past(MEM_STROBE_I, 2))
    else $error("program start not two cycles after strobe");
  a_program_len: assert property (!BUSY_O && busy_len_ff != 8'h0 |-> busy_len_ff == 8'h9b)
    else $error("program run length wrong");
  a_strobe_busy: assert property (DFT_STROBE_O |-> BUSY_O)
    else $error("output strobe outside program");
  a_strobe_pulse: assert property (DFT_STROBE_O |=> !DFT_STROBE_O)
    else $error("output strobe too long");
  a_bin_order: assert property (DFT_STROBE_O && DFT_OUT_O.bin != 3'h7 |-> ##2
    (DFT_STROBE_O && DFT_OUT_O.bin == $past(DFT_OUT_O.bin, 2) + 3'h1))
    else $error("bins out of order");
  a_word_hold: assert property (!DFT_STROBE_O && $past(NRST_I) |-> $stable(DFT_OUT_O.word))
    else $error("output word changed without strobe");
  a_zvf_update: assert property (!$stable(ZVF_MAG_O) && $past(NRST_I) |-> DFT_STROBE_O
    && DFT_OUT_O.bin == 3'h0)
    else $error("zero doppler value changed off bin 0");
endmodule : dgp_preproc_props
bind dgp_preproc dgp_preproc_props dgp_preproc_props_i (.CLK_I(CLK_I), .NRST_I(NRST_I),
  .MEM_STROBE_I(MEM_STROBE_I), .REG_ADDR_I(REG_ADDR_I), .REG_RD_I(REG_RD_I),
  .REG_RDATA_O(REG_RDATA_O), .DFT_STROBE_O(DFT_STROBE_O), .DFT_OUT_O(DFT_OUT_O),
  .ZVF_MAG_O(ZVF_MAG_O), .BUSY_O(BUSY_O));
`default_nettype wire

/* File: dgp_mem_model.sv */
// partner: corner-turning memory playing out one range gate
`timescale 1ns/1ps
`default_nettype none
module dgp_mem_model
  import dgp_pkg::*;
(
  // control from the bench
  input wire logic clk_i,
  input wire logic go_i,
  input wire dgp_sample_t base_i,
  input wire dgp_sample_t spike_i,
  input wire logic [3:0] spk_i,
  // readout toward the block
  output logic strobe_o = 1'b0,
  output var dgp_sample_t sample_o = '0
);
  int n = 10;
  // ten back-to-back strobes; a released bus toggles, never holds
  always @(posedge clk_i) begin
    if (go_i) n = 0;
    else if (n < 10) n = n + 1;
    strobe_o <= (n < 10);
    sample_o <= (n < 10) ? ((n == spk_i) ? spike_i : base_i) : ~sample_o;
  end
endmodule : dgp_mem_model
`default_nettype wire

/* File: dgp_preproc_tb.sv */
// testbench: gate runs, register reads and reset for the preprocessor
`timescale 1ns/1ps
`default_nettype none
module dgp_preproc_tb;
  import dgp_pkg::*;
  typedef struct packed {dgp_sample_t s; logic [1:0] fl; logic [15:0] zero_doppler_filter;} dgp_row_t;
  // constant gates: sample, {interference, saturated}, zero doppler value
  localparam dgp_row_t ROWS [4] = '{'{'{11'h400, 11'h400}, 2'h0, 16'h0000},
    '{'{11'h7ff, 11'h400}, 2'h1, 16'h27f6}, '{'{11'h400, 11'h000}, 2'h1, 16'h2800},
    '{'{11'h480, 11'h3a0}, 2'h0, 16'h08c0}};
  // transform of a lone last-sample spike of 256 on I, bins 0 to 7, {re, im}
  localparam logic [31:0] SPK [8] = '{32'h0100_0000, 32'h00b5_ff4e, 32'h0000_ff00,
    32'hff4b_ff4e, 32'hff00_0000, 32'hff4b_00b2, 32'h0000_0100, 32'h00b5_00b2};
  logic clk = 0, rst_n = 0, go = 0, wr = 0, rd = 0, strb, dstb, busy;
  logic [1:0] addr = '0;
  logic [15:0] wdata = '0, rdata, zero_doppler_filter;
  logic [3:0] spk = '0;
  dgp_sample_t base = '0, spike = '0, smp;
  dgp_result_t res;
  int error_cnt = 0, checked = 0;
  initial forever #25 clk = ~clk;
  dgp_preproc dgp_preproc_i (.CLK_I(clk), .NRST_I(rst_n), .MEM_STROBE_I(strb),
    .MEM_SAMPLE_I(smp), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_RDATA_O(rdata), .DFT_STROBE_O(dstb), .DFT_OUT_O(res),
    .ZVF_MAG_O(zero_doppler_filter), .BUSY_O(busy));
  dgp_mem_model dgp_mem_model_i (.clk_i(clk), .go_i(go), .base_i(base),
    .spike_i(spike), .spk_i(spk), .strobe_o(strb), .sample_o(smp));
  task automatic chk(input logic [36:0] seen, input logic [36:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic reg_rd(input logic [1:0] a, input logic [15:0] exp);
    @(posedge clk) begin rd <= 1'b1; addr <= a; end
    @(posedge clk) rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : reg_rd
  task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
    @(posedge clk) wr <= 1'b0;
  endtask : reg_wr
  // one gate from the memory model, then collect the eight words
  task automatic gate(input dgp_sample_t b, input dgp_sample_t sp, input logic [3:0] k,
                      input logic [1:0] fl, input logic full, input logic [15:0] ez);
    int n;
    n = 0;
    @(posedge clk) begin go <= 1'b1; base <= b; spike <= sp; spk <= k; end
    @(posedge clk) go <= 1'b0;
    repeat (400) begin
      @(negedge clk);
      if (dstb === 1'b1) begin
        chk(res.bin, n[2:0]);
        chk({res.interference, res.saturated}, fl);
        if (full) chk(res.word, '0);
        else if (fl == 2'h2) chk(res.word, SPK[n[2:0]]);
        n++;
      end
    end
    chk(n, 8);
    if (full) chk(zero_doppler_filter, ez);
  endtask : gate
  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    reg_rd(REG_GATES, GATES_RESET);
    for (int r = 0; r < 4; r++) begin
      gate(ROWS[r].s, ROWS[r].s, 4'h0, ROWS[r].fl, 1'b1, ROWS[r].zero_doppler_filter);
      reg_rd(REG_STATUS, {10'h0, ROWS[r].fl, 4'h0});
      reg_rd(REG_GATES, 16'(r + 1));
    end
    gate('{11'h400, 11'h400}, '{11'h500, 11'h400}, 4'h9, 2'h2, 1'b0, '0);
    gate('{11'h480, 11'h3a0}, '{11'h480, 11'h07f}, 4'h9, 2'h1, 1'b0, '0);
    reg_wr(REG_GATES, 16'hffff);
    reg_wr(REG_CTRL, 16'h0001);
    reg_rd(REG_GATES, 16'h0006);
    reg_rd(2'h3, 16'h0000);
    reg_rd(REG_CTRL, 16'h0000);
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    repeat (60) @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk) rst_n <= 1'b1;
    #1 chk({busy, dstb, zero_doppler_filter}, '0);
    reg_rd(REG_GATES, GATES_RESET);
    stop_test();
  end
  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
endmodule : dgp_preproc_tb
`default_nettype wire
